// >>> rtl/wd_pkg.sv
/*
  Constants for the watchdog service and reload block: register offsets,
  field positions, reset values and the service pattern.
  Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
package wd_pkg;
  localparam logic [7:0] OFF_RELOAD     = 8'h00;
  localparam logic [7:0] OFF_SERVICE    = 8'h04;
  localparam logic [7:0] OFF_CONFIG     = 8'h08;
  localparam logic [7:0] OFF_PRESCALER  = 8'h0c;
  localparam logic [7:0] OFF_AUX_RELOAD = 8'h10;
  localparam logic [7:0] OFF_AUX_CTRL   = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;
  localparam logic [7:0] OFF_MASK       = 8'h1c;
  localparam logic [7:0] OFF_WD_COUNT   = 8'h20;

  localparam logic [7:0] RELOAD_RST      = 8'h0f;
  localparam logic [7:0] SERVICE_PATTERN = 8'h5c;
  localparam logic [2:0] PRESCALE_MAX    = 3'h5;

  // Config fields
  localparam int CFG_LOCK_CFG   = 0;
  localparam int CFG_LOCK_PRESC = 1;
  localparam int CFG_LOCK_AUX   = 2;
  localparam int CFG_LOCK_CTRL  = 3;
  localparam int CFG_CLK_SEL    = 4;
  localparam int CFG_MATCH_EN   = 5;
  localparam logic [5:0] CFG_LOCK_BITS = 6'h0f;

  // Aux control fields
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_FREEZE  = 1;

  // Status fields
  localparam int ST_BAD_DATA = 0;
  localparam int ST_DOUBLE   = 1;
  localparam int ST_EXPIRED  = 2;
  localparam int ST_SERVICED = 3;

  typedef enum logic {WD_IDLE, WD_RUN} wd_state_t;
endpackage

// >>> rtl/wd_service_reload.sv
/*
  Watchdog with reload-count start, data-match service port, prescaled
  slow tick, auxiliary reload timer, register lock and freeze control.
  Assumes one AHB-Lite master, slow_tick as a one-cycle pulse per slow
  clock period, and freeze synchronous to hclk.
*/
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module wd_service_reload (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        slow_tick,
  input  wire logic        freeze,
  output logic             wd_error,
  output logic             irq
);
  import wd_pkg::*;

  function automatic logic [4:0] presc_mask(input logic [2:0] sel);
    case (sel)
      3'h0:    presc_mask = 5'h00;
      3'h1:    presc_mask = 5'h01;
      3'h2:    presc_mask = 5'h03;
      3'h3:    presc_mask = 5'h07;
      3'h4:    presc_mask = 5'h0f;
      default: presc_mask = 5'h1f;
    endcase
  endfunction

  // Bus group
  logic        ph_valid_reg, ph_valid_next;
  logic        ph_write_reg, ph_write_next;
  logic [7:0]  ph_addr_reg,  ph_addr_next;
  logic [31:0] hrdata_reg,   hrdata_next;
  logic        hready_reg;
  logic        addr_rd, wr;

  // Core group
  logic [7:0]  reload_reg,     reload_next;
  logic [5:0]  cfg_reg,        cfg_next;
  logic [2:0]  presc_sel_reg,  presc_sel_next;
  logic [7:0]  aux_reload_reg, aux_reload_next;
  logic        freeze_aux_reg, freeze_aux_next;
  logic [4:0]  div_cnt_reg,    div_cnt_next;
  logic [7:0]  aux_cnt_reg,    aux_cnt_next;
  logic [7:0]  wd_cnt_reg,     wd_cnt_next;
  wd_state_t   state_reg,      state_next;
  logic        written_reg,    written_next;
  logic [3:0]  status_reg,     status_next;
  logic [3:0]  mask_reg,       mask_next;
  logic        wd_error_reg,   wd_error_next;
  logic        irq_reg,        irq_next;

  logic        pre_tick, aux_tick, wd_tick, restart_wr, reload_wr, svc_wr;
  logic        bad, dbl, expire, ok;
  logic [4:0]  m;
  logic [7:0]  wdat;

  assign wdat       = hwdata[7:0];
  assign wr         = ph_valid_reg & ph_write_reg;
  assign reload_wr  = wr && (ph_addr_reg == OFF_RELOAD);
  assign restart_wr = wr && (ph_addr_reg == OFF_AUX_CTRL) && !cfg_reg[CFG_LOCK_CTRL]
                      && hwdata[CTRL_RESTART];
  assign addr_rd    = hsel & hready & htrans[1] & !hwrite;

  always_comb begin
    ph_valid_next = hsel & hready & htrans[1];
    ph_write_next = hwrite;
    ph_addr_next  = {haddr[7:2], 2'b00};
    hrdata_next   = 32'h0000_0000;
    if (addr_rd) begin
      case (ph_addr_next)
        OFF_CONFIG:     hrdata_next = {26'h0, cfg_reg};
        OFF_PRESCALER:  hrdata_next = {29'h0, presc_sel_reg};
        OFF_AUX_RELOAD: hrdata_next = {24'h0, aux_reload_reg};
        OFF_AUX_CTRL:   hrdata_next = {30'h0, freeze_aux_reg, 1'b0};
        OFF_STATUS:     hrdata_next = {28'h0, status_reg};
        OFF_MASK:       hrdata_next = {28'h0, mask_reg};
        OFF_WD_COUNT:   hrdata_next = {23'h0, state_reg == WD_RUN, wd_cnt_reg};
        default:        hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 8'h00;
      hrdata_reg   <= 32'h0000_0000;
      hready_reg   <= 1'b0;
    end else begin
      ph_valid_reg <= ph_valid_next;
      ph_write_reg <= ph_write_next;
      ph_addr_reg  <= ph_addr_next;
      hrdata_reg   <= hrdata_next;
      hready_reg   <= 1'b1;
    end
  end

  always_comb begin
    reload_next     = reload_reg;
    cfg_next        = cfg_reg;
    presc_sel_next  = presc_sel_reg;
    aux_reload_next = aux_reload_reg;
    freeze_aux_next = freeze_aux_reg;
    mask_next       = mask_reg;
    div_cnt_next    = div_cnt_reg;
    aux_cnt_next    = aux_cnt_reg;
    wd_cnt_next     = wd_cnt_reg;
    state_next      = state_reg;
    written_next    = written_reg;
    bad             = 1'b0;
    dbl             = 1'b0;
    expire          = 1'b0;
    ok              = 1'b0;
    aux_tick        = 1'b0;
    svc_wr          = wr && (ph_addr_reg == OFF_SERVICE) && cfg_reg[CFG_MATCH_EN];

    if (wr && ph_addr_reg == OFF_CONFIG) begin
      if (!cfg_reg[CFG_LOCK_CFG])
        cfg_next = hwdata[5:0] | (cfg_reg & CFG_LOCK_BITS);
    end
    if (wr && ph_addr_reg == OFF_PRESCALER && !cfg_reg[CFG_LOCK_PRESC]) begin
      presc_sel_next = (hwdata[2:0] > PRESCALE_MAX) ? PRESCALE_MAX : hwdata[2:0];
    end
    if (wr && ph_addr_reg == OFF_AUX_RELOAD && !cfg_reg[CFG_LOCK_AUX])
      aux_reload_next = wdat;
    if (wr && ph_addr_reg == OFF_AUX_CTRL && !cfg_reg[CFG_LOCK_CTRL])
      freeze_aux_next = hwdata[CTRL_FREEZE];
    if (wr && ph_addr_reg == OFF_MASK)
      mask_next = hwdata[3:0];

    m = presc_mask(presc_sel_reg);
    if (slow_tick)
      div_cnt_next = div_cnt_reg + 5'h01;
    pre_tick = slow_tick && ((div_cnt_reg & m) == m);

    if (restart_wr) begin
      aux_cnt_next = aux_reload_reg;
    end else if (!(freeze && freeze_aux_reg) && pre_tick) begin
      if (aux_cnt_reg == 8'h00) begin
        aux_tick     = 1'b1;
        aux_cnt_next = aux_reload_reg;
      end else begin
        aux_cnt_next = aux_cnt_reg - 8'h01;
      end
    end

    // Watchdog clock select; watchdog frozen by freeze whether or not freeze_aux_reg is set
    wd_tick = !freeze && (cfg_reg[CFG_CLK_SEL] ? pre_tick : aux_tick);

    if (reload_wr) begin
      reload_next  = wdat;
      // First write starts; later writes restart
      wd_cnt_next  = wdat;
      state_next   = WD_RUN;
      written_next = 1'b0;
    end else if (svc_wr) begin
      written_next = 1'b1;
      if (wdat != SERVICE_PATTERN) begin
        bad = 1'b1;
      end else if (written_reg) begin
        dbl = 1'b1;
      end else begin
        ok          = 1'b1;
        wd_cnt_next = reload_reg;
      end
    end else if (state_reg == WD_RUN && wd_tick) begin
      written_next = 1'b0;
      if (wd_cnt_reg == 8'h00) begin
        expire      = 1'b1;
        wd_cnt_next = reload_reg;
      end else begin
        wd_cnt_next = wd_cnt_reg - 8'h01;
      end
    end
    // Writes with matching off fall through untouched

    wd_error_next = bad | dbl | expire;
    // Set beats the read clear
    status_next = (addr_rd && ph_addr_next == OFF_STATUS) ? 4'h0 : status_reg;
    status_next = status_next | {ok, expire, dbl, bad};
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_reg     <= RELOAD_RST;
      cfg_reg        <= 6'h00;
      presc_sel_reg  <= 3'h0;
      aux_reload_reg <= 8'h00;
      freeze_aux_reg <= 1'b0;
      mask_reg       <= 4'h0;
      div_cnt_reg    <= 5'h00;
      aux_cnt_reg    <= 8'h00;
      wd_cnt_reg     <= RELOAD_RST;
      state_reg      <= WD_IDLE;
      written_reg    <= 1'b0;
      status_reg     <= 4'h0;
      wd_error_reg   <= 1'b0;
      irq_reg        <= 1'b0;
    end else begin
      reload_reg     <= reload_next;
      cfg_reg        <= cfg_next;
      presc_sel_reg  <= presc_sel_next;
      aux_reload_reg <= aux_reload_next;
      freeze_aux_reg <= freeze_aux_next;
      mask_reg       <= mask_next;
      div_cnt_reg    <= div_cnt_next;
      aux_cnt_reg    <= aux_cnt_next;
      wd_cnt_reg     <= wd_cnt_next;
      state_reg      <= state_next;
      written_reg    <= written_next;
      status_reg     <= status_next;
      wd_error_reg   <= wd_error_next;
      irq_reg        <= irq_next;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp     = 1'b0;
  assign wd_error  = wd_error_reg;
  assign irq       = irq_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FREEZE_AUX: assert property (
    freeze && freeze_aux_reg && !restart_wr |=> $stable(aux_cnt_reg))
    else $error("aux timer moved while frozen");

  AST_FREEZE_WD: assert property (
    freeze && !ph_valid_reg |=> $stable(wd_cnt_reg) && !wd_error_reg)
    else $error("watchdog moved while frozen");

  AST_RELOAD_WRITE: assert property (
    reload_wr |=> wd_cnt_reg == $past(hwdata[7:0]) && reload_reg == $past(hwdata[7:0])
                  && state_reg == WD_RUN)
    else $error("reload write did not restart count");

  AST_IDLE_UNTIL_WRITE: assert property (
    state_reg == WD_IDLE && !reload_wr |=> state_reg == WD_IDLE && !wd_error_reg)
    else $error("watchdog left idle without reload write");

  AST_SERVICE_OK: assert property (
    svc_wr && wdat == SERVICE_PATTERN && !written_reg
      |=> wd_cnt_reg == $past(reload_reg) && !wd_error_reg && status_reg[ST_SERVICED])
    else $error("good service did not reload");

  AST_BAD_PATTERN: assert property (
    svc_wr && wdat != SERVICE_PATTERN |=> wd_error_reg && status_reg[ST_BAD_DATA])
    else $error("bad pattern raised no error");

  AST_DOUBLE_SERVICE: assert property (
    svc_wr && written_reg |=> wd_error_reg)
    else $error("second service in one tick raised no error");

  AST_SERVICE_OFF: assert property (
    wr && ph_addr_reg == OFF_SERVICE && !cfg_reg[CFG_MATCH_EN] && !wd_tick
      |=> $stable(wd_cnt_reg) && !wd_error_reg)
    else $error("disabled service port had an effect");

  AST_PRESCALE_FULL: assert property (
    presc_sel_reg == 3'h0 && slow_tick |-> pre_tick)
    else $error("undivided prescaler missed a slow tick");

  AST_AUX_TICK: assert property (
    aux_tick |-> pre_tick && aux_cnt_reg == 8'h00
      ##1 aux_cnt_reg == $past(aux_reload_reg))
    else $error("aux tick not at count end");

  AST_EXPIRE: assert property (
    state_reg == WD_RUN && wd_tick && wd_cnt_reg == 8'h00 && !ph_valid_reg
      |=> wd_error_reg && status_reg[ST_EXPIRED])
    else $error("expiry raised no error");

  AST_CONFIG_LOCK: assert property (
    cfg_reg[CFG_LOCK_CFG] |=> $stable(cfg_reg))
    else $error("locked config changed");

  AST_RELOAD_RESET: assert property (
    state_reg == WD_IDLE |-> reload_reg == RELOAD_RST)
    else $error("reload count lost its reset value before start");

  AST_WRITE_ONLY: assert property (
    addr_rd && (ph_addr_next == OFF_RELOAD || ph_addr_next == OFF_SERVICE)
      |=> hrdata_reg == 32'h0000_0000)
    else $error("write-only register returned data");

  AST_CLOCK_SELECT: assert property (
    state_reg == WD_RUN && !freeze && !wr && wd_cnt_reg != 8'h00
      && (cfg_reg[CFG_CLK_SEL] ? pre_tick : aux_tick)
      |=> wd_cnt_reg == $past(wd_cnt_reg) - 8'h01)
    else $error("selected tick did not decrement watchdog");

  AST_AUX_RESTART: assert property (
    restart_wr |=> aux_cnt_reg == $past(aux_reload_reg))
    else $error("aux restart did not load reload value");

  // Level interrupt tracks status
  AST_IRQ_LEVEL: assert property (
    irq_reg == |(status_reg & mask_reg))
    else $error("irq does not follow masked status");

  // Status clear on read
  AST_STATUS_CLEAR: assert property (
    addr_rd && ph_addr_next == OFF_STATUS && !wr && !wd_tick
      |=> status_reg == 4'h0)
    else $error("status read did not clear");

  // Zero-wait slave
  AST_READY_HIGH: assert property (
    hresetn |=> hready_reg)
    else $error("slave inserted a wait state");

  AST_WRITTEN_CLEAR: assert property (
    state_reg == WD_RUN && wd_tick && !wr |=> !written_reg)
    else $error("watchdog tick left service flag set");

  AST_LOCK_STICKY: assert property (
    1'b1 |=> (cfg_reg & $past(cfg_reg) & CFG_LOCK_BITS)
             == ($past(cfg_reg) & CFG_LOCK_BITS))
    else $error("lock bit cleared before reset");

  AST_PRESC_LOCK: assert property (
    cfg_reg[CFG_LOCK_PRESC] |=> $stable(presc_sel_reg))
    else $error("locked prescaler changed");

  AST_AUX_LOCK: assert property (
    cfg_reg[CFG_LOCK_AUX] |=> $stable(aux_reload_reg))
    else $error("locked aux reload changed");
endmodule // wd_service_reload
`default_nettype wire

// >>> verif/wd_service_reload_tb.sv
/*
  Self-checking bench for the watchdog service and reload block.
  Assumes the package constants, zero-wait AHB-Lite answers and hready tied to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module wd_service_reload_tb;
  import wd_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        slow_tick = 1'b0;
  logic        freeze = 1'b0;
  logic        wd_error;
  logic        irq;
  int          miscompares = 0;
  int          checks_done = 0;
  int          err_count = 0;
  logic [31:0] v;

  always #12.5 hclk = ~hclk;

  wd_service_reload wd_service_reload_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slow_tick(slow_tick), .freeze(freeze),
    .wd_error(wd_error), .irq(irq));

  // Error pulses counted as sampled at each edge
  always @(posedge hclk) if (wd_error === 1'b1) err_count <= err_count + 1;

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      slow_tick <= 1'b1;
      @(posedge hclk);
      slow_tick <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask

  task automatic t_reset;
    rd(OFF_WD_COUNT, v); chk({31'h0, v[8]}, 32'h0, "idle after reset");
    chk({24'h0, v[7:0]}, {24'h0, RELOAD_RST}, "count holds reset reload");
    chk({31'h0, hresp}, 32'h0, "okay response");
    rd(OFF_RELOAD, v); chk(v, 32'h0, "reload reads 0");
    rd(OFF_AUX_CTRL, v); chk(v, 32'h0, "freeze enable reset");
    rd(8'h3c, v); chk(v, 32'h0, "unmapped read");
    wr(OFF_CONFIG, 32'h10);
    tick(3);
    rd(OFF_WD_COUNT, v); chk({31'h0, v[8]}, 32'h0, "no count before start");
    chk(err_count, 0, "no error while idle");
    $display("test reset done");
  endtask

  task automatic t_aux;
    wr(OFF_PRESCALER, 32'h7);
    rd(OFF_PRESCALER, v); chk(v, {29'h0, PRESCALE_MAX}, "prescaler max");
    wr(OFF_PRESCALER, 32'h0);
    wr(OFF_AUX_RELOAD, 32'h1);
    wr(OFF_CONFIG, 32'h00);
    wr(OFF_RELOAD, 32'h3);
    wr(OFF_AUX_CTRL, 32'h1);
    rd(OFF_WD_COUNT, v); chk(v, 32'h103, "started by reload write");
    tick(4);
    rd(OFF_WD_COUNT, v); chk(v, 32'h101, "aux tick every 2");
    chk(err_count, 0, "no error on aux run");
    wr(OFF_AUX_CTRL, 32'h3);
    rd(OFF_AUX_CTRL, v); chk(v, 32'h2, "freeze enable set");
    freeze <= 1'b1;
    tick(1);
    freeze <= 1'b0;
    tick(1);
    rd(OFF_WD_COUNT, v); chk(v, 32'h101, "aux timer frozen");
    wr(OFF_AUX_CTRL, 32'h0);
    wr(OFF_CONFIG, 32'h10);
    wr(OFF_PRESCALER, 32'h1);
    wr(OFF_RELOAD, 32'h4);
    tick(4);
    rd(OFF_WD_COUNT, v); chk(v, 32'h102, "half-rate prescaled tick");
    wr(OFF_PRESCALER, 32'h0);
    $display("test aux done");
  endtask

  task automatic t_start;
    int e0;
    wr(OFF_CONFIG, 32'h10);
    wr(OFF_MASK, 32'h4);
    wr(OFF_RELOAD, 32'h3);
    tick(2);
    rd(OFF_WD_COUNT, v); chk(v, 32'h101, "decrement per tick");
    wr(OFF_RELOAD, 32'h5);
    rd(OFF_WD_COUNT, v); chk(v, 32'h105, "restart with new value");
    e0 = err_count;
    tick(5);
    chk(err_count, e0, "no error at zero");
    chk({31'h0, irq}, 32'h0, "irq quiet");
    tick(1);
    chk(err_count, e0 + 1, "expiry error");
    chk({31'h0, irq}, 32'h1, "irq on expiry");
    rd(OFF_WD_COUNT, v); chk(v, 32'h105, "reload on expiry");
    rd(OFF_STATUS, v); chk(v, 32'h4, "expiry status");
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    $display("test start done");
  endtask

  task automatic t_freeze;
    freeze <= 1'b1;
    tick(2);
    rd(OFF_WD_COUNT, v); chk(v, 32'h105, "watchdog frozen");
    freeze <= 1'b0;
    tick(1);
    rd(OFF_WD_COUNT, v); chk(v, 32'h104, "runs after freeze");
    $display("test freeze done");
  endtask

  task automatic t_service;
    int e0;
    e0 = err_count;
    wr(OFF_SERVICE, 32'h11);
    wr(OFF_SERVICE, 32'h5c);
    rd(OFF_WD_COUNT, v); chk(v, 32'h104, "service ignored when off");
    chk(err_count, e0, "no error when off");
    wr(OFF_CONFIG, 32'h3f);
    wr(OFF_CONFIG, 32'h00);
    rd(OFF_CONFIG, v); chk(v, 32'h3f, "config locked");
    tick(2);
    wr(OFF_SERVICE, 32'h5c);
    rd(OFF_WD_COUNT, v); chk(v, 32'h105, "service reloads");
    chk(err_count, e0, "good service no error");
    wr(OFF_SERVICE, 32'h5c);
    repeat (2) @(posedge hclk);
    chk(err_count, e0 + 1, "double service");
    tick(1);
    wr(OFF_SERVICE, 32'ha5);
    repeat (2) @(posedge hclk);
    chk(err_count, e0 + 2, "bad pattern");
    rd(OFF_STATUS, v); chk(v, 32'hb, "service status");
    $display("test service done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_aux();
    t_start();
    t_freeze();
    t_service();
    end_of_test();
  end

  // Hang guard well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    end_of_test();
  end
endmodule // wd_service_reload_tb
`default_nettype wire
